/* File: dasf_pkg.sv */
// constants and types shared by the dual converter status block
package dasf_pkg;

  // ********************************************************
  // special-function register addresses
  // ********************************************************
  localparam logic [7:0] ADDR_STATUS      = 8'hd8;
  localparam logic [7:0] ADDR_MODE        = 8'hd1;
  localparam logic [7:0] ADDR_PRI_CFG     = 8'hd2;
  localparam logic [7:0] ADDR_AUX_CFG     = 8'hd3;
  localparam logic [7:0] ADDR_SINC        = 8'hd4;
  localparam logic [7:0] ADDR_PRI_RES_LO  = 8'hd9;
  localparam logic [7:0] ADDR_PRI_RES_HI  = 8'hda;
  localparam logic [7:0] ADDR_AUX_RES_LO  = 8'hdb;
  localparam logic [7:0] ADDR_AUX_RES_HI  = 8'hdc;
  localparam logic [7:0] ADDR_PRI_OFS_LO  = 8'he1;
  localparam logic [7:0] ADDR_PRI_OFS_HI  = 8'he2;
  localparam logic [7:0] ADDR_AUX_OFS_LO  = 8'he3;
  localparam logic [7:0] ADDR_AUX_OFS_HI  = 8'he4;
  localparam logic [7:0] ADDR_PRI_GAIN_LO = 8'he9;
  localparam logic [7:0] ADDR_PRI_GAIN_HI = 8'hea;
  localparam logic [7:0] ADDR_AUX_GAIN_LO = 8'heb;
  localparam logic [7:0] ADDR_AUX_GAIN_HI = 8'hec;

  // ********************************************************
  // status register bit positions
  // ********************************************************
  localparam int BIT_PRI_DONE   = 7;
  localparam int BIT_AUX_DONE   = 6;
  localparam int BIT_CAL_DONE   = 5;
  localparam int BIT_MISS_REF   = 4;
  localparam int BIT_PRI_FAULT  = 3;
  localparam int BIT_AUX_FAULT  = 2;

  // ********************************************************
  // mode register fields
  // ********************************************************
  localparam int BIT_PRI_EN     = 5;
  localparam int BIT_AUX_EN     = 4;
  localparam int MODE_LSB       = 0;
  localparam int MODE_W         = 3;
  // external reference select inside each config register
  localparam int BIT_CFG_XREF   = 6;

  typedef enum logic [2:0] {
    MODE_POWER_DOWN = 3'b000,
    MODE_IDLE       = 3'b001,
    MODE_SINGLE     = 3'b010,
    MODE_CONTINUOUS = 3'b011,
    MODE_INT_ZERO   = 3'b100,
    MODE_INT_FULL   = 3'b101,
    MODE_SYS_ZERO   = 3'b110,
    MODE_SYS_FULL   = 3'b111
  } dasf_mode_t;

  // ********************************************************
  // reset values, the all-ones clamp value and the unmapped read byte
  // ********************************************************
  localparam logic [7:0]  RST_STATUS   = 8'h00;
  localparam logic [7:0]  RST_MODE     = 8'h00;
  localparam logic [7:0]  RST_CFG      = 8'h00;
  localparam logic [7:0]  RST_SINC     = 8'h45;
  localparam logic [15:0] RST_RESULT   = 16'h0000;
  localparam logic [15:0] FACTORY_OFS  = 16'h8000;
  localparam logic [15:0] FACTORY_GAIN = 16'h5555;
  localparam logic [15:0] CLAMP_ONES   = 16'hffff;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;

endpackage : dasf_pkg

/* File: dasf_status.sv */
// status flags and register file for two sigma-delta converters
// ********************************************************
// How it works
// - primary completion sets status bit 7
// - primary ready cleared by write or by mode start with primary enabled
// - set primary ready blocks result/coefficient writes
// - bit 6 mirrors ready for auxiliary
// - calibration completion on either converter sets bit 5 while its ready bit is clear
// - calibration flag cleared only by mode start
// - bit 4 shows missing reference while active
// - missing external reference forces all-ones results
// - bit 3 set when primary result clamped
// - bit 3 flags calibration fault after calibration
// - mode start with primary enabled clears primary fault flag
// - bit 2 is auxiliary fault flag
// - status bits 1 and 0 reserved
// - status register supports single-bit access
// - result, offset, gain as byte pairs
// - coefficients load factory values at power-up
// - sinc register sets decimation for both
// - single conversion returns mode field to 000
// ********************************************************
`timescale 1ns/1ps

module dasf_status (
  input  wire logic        clk,
  input  wire logic        reset_n,
  // byte access to special-function registers
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  // single-bit access
  input  wire logic [7:0]  bit_addr,
  input  wire logic        bit_wr,
  input  wire logic        bit_rd,
  input  wire logic        bit_wdata,
  output logic             bit_rdata,
  // primary converter events
  input  wire logic        pri_conv_done,
  input  wire logic        pri_cal_done,
  input  wire logic        pri_clamped,
  input  wire logic        pri_cal_fault,
  input  wire logic [15:0] pri_value,
  // auxiliary converter events
  input  wire logic        aux_conv_done,
  input  wire logic        aux_cal_done,
  input  wire logic        aux_clamped,
  input  wire logic        aux_cal_fault,
  input  wire logic [15:0] aux_value,
  // reference detector, asynchronous pin level
  input  wire logic        reference_input_pins_bad,
  // to the converters
  output logic             pri_enable,
  output logic             aux_enable,
  output logic      [2:0]  mode_select_field,
  output logic      [7:0]  primary_config_reg,
  output logic      [7:0]  auxiliary_config_reg,
  output logic      [7:0]  sinc_decimation_reg
);

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    logic [2:0]       ref_sync;
    logic             ref_level;
    logic [1:0]       done_flag;
    logic             cal_flag;
    logic             miss_ref;
    logic [1:0]       fault_flag;
    logic [7:0]       mode;
    logic [1:0][7:0]  cfg;
    logic [7:0]       sinc;
    logic [1:0][15:0] result;
    logic [1:0][15:0] offset;
    logic [1:0][15:0] gain;
    logic [7:0]       rdata;
    logic             bdata;
  } dasf_state_t;

  dasf_state_t st_q;
  dasf_state_t st_d;

  logic [1:0]  conv_done;
  logic [1:0]  cal_done;
  logic [1:0]  clamped;
  logic [1:0]  cal_fault;
  logic [1:0][15:0] value;
  logic [7:0]  status_byte;

  assign conv_done = {aux_conv_done, pri_conv_done};
  assign cal_done  = {aux_cal_done, pri_cal_done};
  assign clamped   = {aux_clamped, pri_clamped};
  assign cal_fault = {aux_cal_fault, pri_cal_fault};
  assign value     = {aux_value, pri_value};

  // ********************************************************
  // status byte assembly
  // ********************************************************
  always_comb
  begin
    status_byte                          = dasf_pkg::RST_STATUS;
    status_byte[dasf_pkg::BIT_PRI_DONE]  = st_q.done_flag[0];
    status_byte[dasf_pkg::BIT_AUX_DONE]  = st_q.done_flag[1];
    status_byte[dasf_pkg::BIT_CAL_DONE]  = st_q.cal_flag;
    status_byte[dasf_pkg::BIT_MISS_REF]  = st_q.miss_ref;
    status_byte[dasf_pkg::BIT_PRI_FAULT] = st_q.fault_flag[0];
    status_byte[dasf_pkg::BIT_AUX_FAULT] = st_q.fault_flag[1];
    // bits 1 and 0 stay zero
  end

  // ********************************************************
  // next state
  // ********************************************************
  always_comb
  begin
    logic        mode_start;
    logic [2:0]  new_mode;
    logic [1:0]  en_now;
    logic [1:0]  en_new;
    logic [1:0]  sw_clr_done;
    logic [1:0]  sw_set_done;
    logic [1:0]  set_done;
    logic [1:0]  set_fault;
    logic        set_cal;
    logic        is_cal;
    logic        to_gain;
    logic        single_end;
    logic [15:0] res_val;
    int          c;

    mode_start  = 1'b0;
    new_mode    = 3'b000;
    en_now      = 2'b00;
    en_new      = 2'b00;
    sw_clr_done = 2'b00;
    sw_set_done = 2'b00;
    set_done    = 2'b00;
    set_fault   = 2'b00;
    set_cal     = 1'b0;
    is_cal      = 1'b0;
    to_gain     = 1'b0;
    single_end  = 1'b0;
    res_val     = dasf_pkg::RST_RESULT;
    c           = 0;
    st_d        = st_q;

    // three-stage synchroniser, second and third must agree
    st_d.ref_sync = {st_q.ref_sync[1:0], reference_input_pins_bad};
    if (st_q.ref_sync[1] == st_q.ref_sync[2])
    begin
      st_d.ref_level = st_q.ref_sync[2];
    end

    en_now = {st_q.mode[dasf_pkg::BIT_AUX_EN],
              st_q.mode[dasf_pkg::BIT_PRI_EN]};
    // flag only meaningful while a converter is running
    st_d.miss_ref = st_q.ref_level && (en_now != 2'b00);

    is_cal  = st_q.mode[2];
    // zero-scale modes produce offset, full-scale modes gain
    to_gain = st_q.mode[0];

    // ------- register writes -------
    if (sfr_wr)
    begin
      unique case (sfr_addr)
        dasf_pkg::ADDR_STATUS:
        begin
          // only the ready bits are software-writable
          sw_clr_done[0] = !sfr_wdata[dasf_pkg::BIT_PRI_DONE];
          sw_clr_done[1] = !sfr_wdata[dasf_pkg::BIT_AUX_DONE];
          sw_set_done[0] = sfr_wdata[dasf_pkg::BIT_PRI_DONE];
          sw_set_done[1] = sfr_wdata[dasf_pkg::BIT_AUX_DONE];
        end
        dasf_pkg::ADDR_MODE:
        begin
          st_d.mode  = sfr_wdata;
          new_mode   = sfr_wdata[dasf_pkg::MODE_LSB +: dasf_pkg::MODE_W];
          en_new     = {sfr_wdata[dasf_pkg::BIT_AUX_EN],
                        sfr_wdata[dasf_pkg::BIT_PRI_EN]};
          // power-down and idle start nothing
          mode_start = (new_mode != dasf_pkg::MODE_POWER_DOWN) &&
                       (new_mode != dasf_pkg::MODE_IDLE);
        end
        dasf_pkg::ADDR_PRI_CFG:     st_d.cfg[0] = sfr_wdata;
        dasf_pkg::ADDR_AUX_CFG:     st_d.cfg[1] = sfr_wdata;
        dasf_pkg::ADDR_SINC:        st_d.sinc   = sfr_wdata;
        dasf_pkg::ADDR_PRI_RES_LO:  st_d.result[0][7:0]  = sfr_wdata;
        dasf_pkg::ADDR_PRI_RES_HI:  st_d.result[0][15:8] = sfr_wdata;
        dasf_pkg::ADDR_AUX_RES_LO:  st_d.result[1][7:0]  = sfr_wdata;
        dasf_pkg::ADDR_AUX_RES_HI:  st_d.result[1][15:8] = sfr_wdata;
        dasf_pkg::ADDR_PRI_OFS_LO:  st_d.offset[0][7:0]  = sfr_wdata;
        dasf_pkg::ADDR_PRI_OFS_HI:  st_d.offset[0][15:8] = sfr_wdata;
        dasf_pkg::ADDR_AUX_OFS_LO:  st_d.offset[1][7:0]  = sfr_wdata;
        dasf_pkg::ADDR_AUX_OFS_HI:  st_d.offset[1][15:8] = sfr_wdata;
        dasf_pkg::ADDR_PRI_GAIN_LO: st_d.gain[0][7:0]    = sfr_wdata;
        dasf_pkg::ADDR_PRI_GAIN_HI: st_d.gain[0][15:8]   = sfr_wdata;
        dasf_pkg::ADDR_AUX_GAIN_LO: st_d.gain[1][7:0]    = sfr_wdata;
        dasf_pkg::ADDR_AUX_GAIN_HI: st_d.gain[1][15:8]   = sfr_wdata;
        default: ;
      endcase
    end

    // single-bit writes into the status register
    if (bit_wr && (bit_addr[7:3] == dasf_pkg::ADDR_STATUS[7:3]))
    begin
      if (bit_addr[2:0] == 3'(dasf_pkg::BIT_PRI_DONE))
      begin
        sw_clr_done[0] = !bit_wdata;
        sw_set_done[0] = bit_wdata;
      end
      if (bit_addr[2:0] == 3'(dasf_pkg::BIT_AUX_DONE))
      begin
        sw_clr_done[1] = !bit_wdata;
        sw_set_done[1] = bit_wdata;
      end
    end

    // ------- converter completion events -------
    for (c = 0; c < 2; c++)
    begin
      // an unread result blocks everything from this converter
      if (!st_q.done_flag[c])
      begin
        if (conv_done[c])
        begin
          set_done[c] = 1'b1;
          res_val     = value[c];
          if (st_q.miss_ref && st_q.cfg[c][dasf_pkg::BIT_CFG_XREF])
          begin
            res_val = dasf_pkg::CLAMP_ONES;
          end
          st_d.result[c] = res_val;
          if (clamped[c] || (res_val == dasf_pkg::CLAMP_ONES) ||
              (res_val == dasf_pkg::RST_RESULT))
          begin
            set_fault[c] = 1'b1;
          end
        end
        else if (cal_done[c])
        begin
          set_done[c] = 1'b1;
          set_cal     = 1'b1;
          if (cal_fault[c])
          begin
            set_fault[c] = 1'b1;
          end
          else if (to_gain)
          begin
            st_d.gain[c] = value[c];
          end
          else
          begin
            st_d.offset[c] = value[c];
          end
        end
      end
    end

    // single conversion falls back to power-down when done
    if (((set_done[0] && en_now[0]) || (set_done[1] && en_now[1])) &&
        (st_q.mode[dasf_pkg::MODE_LSB +: dasf_pkg::MODE_W] ==
         dasf_pkg::MODE_SINGLE) && !is_cal)
    begin
      single_end = 1'b1;
    end
    if (single_end && !(sfr_wr && (sfr_addr == dasf_pkg::ADDR_MODE)))
    begin
      st_d.mode[dasf_pkg::MODE_LSB +: dasf_pkg::MODE_W] =
        dasf_pkg::MODE_POWER_DOWN;
    end

    // ------- flag update, set wins over any clear -------
    for (c = 0; c < 2; c++)
    begin
      if (set_done[c] || sw_set_done[c])
      begin
        st_d.done_flag[c] = 1'b1;
      end
      else if (sw_clr_done[c] || (mode_start && en_new[c]))
      begin
        st_d.done_flag[c] = 1'b0;
      end
      if (set_fault[c])
      begin
        st_d.fault_flag[c] = 1'b1;
      end
      else if (mode_start && en_new[c])
      begin
        st_d.fault_flag[c] = 1'b0;
      end
    end
    if (set_cal)
    begin
      st_d.cal_flag = 1'b1;
    end
    else if (mode_start)
    begin
      st_d.cal_flag = 1'b0;
    end

    // ------- read data, registered one cycle later -------
    if (sfr_rd)
    begin
      unique case (sfr_addr)
        dasf_pkg::ADDR_STATUS:      st_d.rdata = status_byte;
        dasf_pkg::ADDR_MODE:        st_d.rdata = st_q.mode;
        dasf_pkg::ADDR_PRI_CFG:     st_d.rdata = st_q.cfg[0];
        dasf_pkg::ADDR_AUX_CFG:     st_d.rdata = st_q.cfg[1];
        dasf_pkg::ADDR_SINC:        st_d.rdata = st_q.sinc;
        dasf_pkg::ADDR_PRI_RES_LO:  st_d.rdata = st_q.result[0][7:0];
        dasf_pkg::ADDR_PRI_RES_HI:  st_d.rdata = st_q.result[0][15:8];
        dasf_pkg::ADDR_AUX_RES_LO:  st_d.rdata = st_q.result[1][7:0];
        dasf_pkg::ADDR_AUX_RES_HI:  st_d.rdata = st_q.result[1][15:8];
        dasf_pkg::ADDR_PRI_OFS_LO:  st_d.rdata = st_q.offset[0][7:0];
        dasf_pkg::ADDR_PRI_OFS_HI:  st_d.rdata = st_q.offset[0][15:8];
        dasf_pkg::ADDR_AUX_OFS_LO:  st_d.rdata = st_q.offset[1][7:0];
        dasf_pkg::ADDR_AUX_OFS_HI:  st_d.rdata = st_q.offset[1][15:8];
        dasf_pkg::ADDR_PRI_GAIN_LO: st_d.rdata = st_q.gain[0][7:0];
        dasf_pkg::ADDR_PRI_GAIN_HI: st_d.rdata = st_q.gain[0][15:8];
        dasf_pkg::ADDR_AUX_GAIN_LO: st_d.rdata = st_q.gain[1][7:0];
        dasf_pkg::ADDR_AUX_GAIN_HI: st_d.rdata = st_q.gain[1][15:8];
        default:                    st_d.rdata = dasf_pkg::ZERO_BYTE;
      endcase
    end
    if (bit_rd)
    begin
      st_d.bdata = (bit_addr[7:3] == dasf_pkg::ADDR_STATUS[7:3]) &&
                   status_byte[bit_addr[2:0]];
    end
  end

  // ********************************************************
  // state register
  // ********************************************************
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_q            <= '0;
      st_q.mode       <= dasf_pkg::RST_MODE;
      st_q.cfg        <= {dasf_pkg::RST_CFG, dasf_pkg::RST_CFG};
      st_q.sinc       <= dasf_pkg::RST_SINC;
      st_q.result     <= {dasf_pkg::RST_RESULT, dasf_pkg::RST_RESULT};
      // factory trim values restored at power-up
      st_q.offset     <= {dasf_pkg::FACTORY_OFS, dasf_pkg::FACTORY_OFS};
      st_q.gain       <= {dasf_pkg::FACTORY_GAIN,
                          dasf_pkg::FACTORY_GAIN};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign sfr_rdata            = st_q.rdata;
  assign bit_rdata            = st_q.bdata;
  assign pri_enable           = st_q.mode[dasf_pkg::BIT_PRI_EN];
  assign aux_enable           = st_q.mode[dasf_pkg::BIT_AUX_EN];
  assign mode_select_field    =
    st_q.mode[dasf_pkg::MODE_LSB +: dasf_pkg::MODE_W];
  assign primary_config_reg   = st_q.cfg[0];
  assign auxiliary_config_reg = st_q.cfg[1];
  assign sinc_decimation_reg  = st_q.sinc;

endmodule : dasf_status

/* File: dasf_status_assertions.sv */
// concurrent checks on the converter status block ports
`timescale 1ns/1ps

module dasf_assertions (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic [7:0]  bit_addr,
  input wire logic        bit_wr,
  input wire logic        bit_rd,
  input wire logic        bit_wdata,
  input wire logic        bit_rdata,
  input wire logic        pri_conv_done,
  input wire logic        pri_cal_done,
  input wire logic [15:0] pri_value,
  input wire logic        pri_enable,
  input wire logic [2:0]  mode_select_field,
  input wire logic [7:0]  primary_config_reg,
  input wire logic [7:0]  sinc_decimation_reg
);
  // ********************************************************
  // shadow of the primary ready flag and result low byte
  // ********************************************************
  logic       rdy_q;
  logic [7:0] res_q;
  logic       ok_q;
  logic       take;
  logic       start;

  assign take  = (pri_conv_done || pri_cal_done) && !rdy_q;
  assign start = sfr_wr && sfr_addr == dasf_pkg::ADDR_MODE
                 && sfr_wdata[2:1] != 2'b00 && sfr_wdata[5];

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rdy_q <= 1'b0;
      res_q <= 8'h00;
      ok_q  <= 1'b1;
    end
    else
    begin
      // set beats any clear
      if (take)
        rdy_q <= 1'b1;
      else if (bit_wr && bit_addr == 8'hdf)
        rdy_q <= bit_wdata;
      else if (sfr_wr && sfr_addr == dasf_pkg::ADDR_STATUS)
        rdy_q <= sfr_wdata[7];
      else if (start)
        rdy_q <= 1'b0;
      // external reference may force ones, so stop checking then
      if (pri_conv_done && !rdy_q)
      begin
        res_q <= pri_value[7:0];
        ok_q  <= !primary_config_reg[6];
      end
    end
  end

  // ********************************************************
  // properties
  // ********************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_rdy_read;
    sfr_rd && sfr_addr == dasf_pkg::ADDR_STATUS
    |=> sfr_rdata[7] == $past(rdy_q);
  endproperty
  a_rdy_read: assert property (p_rdy_read)
    else $error("status bit 7 disagrees with ready history");

  property p_res_hold;
    sfr_rd && sfr_addr == dasf_pkg::ADDR_PRI_RES_LO && ok_q
    |=> sfr_rdata == $past(res_q);
  endproperty
  a_res_hold: assert property (p_res_hold)
    else $error("primary result low byte wrong");

  property p_single_end;
    mode_select_field == dasf_pkg::MODE_SINGLE && pri_enable
    && pri_conv_done && !rdy_q
    && !(sfr_wr && sfr_addr == dasf_pkg::ADDR_MODE)
    |=> mode_select_field == 3'b000;
  endproperty
  a_single_end: assert property (p_single_end)
    else $error("single conversion did not return to power-down");

  property p_rd_hold;
    !sfr_rd |=> $stable(sfr_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");

  property p_resv;
    sfr_rd && sfr_addr == dasf_pkg::ADDR_STATUS
    |=> sfr_rdata[1:0] == 2'b00;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved status bits not zero");

  property p_bit_resv;
    bit_rd && (bit_addr == 8'hd8 || bit_addr == 8'hd9) |=> !bit_rdata;
  endproperty
  a_bit_resv: assert property (p_bit_resv)
    else $error("reserved status bit read as one");

  property p_bit_status;
    bit_rd && bit_addr == 8'hdf |=> bit_rdata == $past(rdy_q);
  endproperty
  a_bit_status: assert property (p_bit_status)
    else $error("single-bit read of ready flag wrong");

  property p_sinc;
    sfr_wr && sfr_addr == dasf_pkg::ADDR_SINC
    |=> sinc_decimation_reg == $past(sfr_wdata);
  endproperty
  a_sinc: assert property (p_sinc)
    else $error("decimation register not written");

  c_take:  cover property (take);
  c_start: cover property (start);
  c_block: cover property (pri_conv_done && rdy_q);

endmodule : dasf_assertions

/* File: tb_top.sv */
// self-checking bench for the converter status block
`timescale 1ns/1ps

module tb_top;
  logic        clk;
  logic        reset_n;
  logic [7:0]  sfr_addr;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic [7:0]  bit_addr;
  logic        bit_wr;
  logic        bit_rd;
  logic        bit_wdata;
  logic        bit_rdata;
  logic        pri_conv_done;
  logic        pri_cal_done;
  logic        pri_clamped;
  logic        pri_cal_fault;
  logic [15:0] pri_value;
  logic        aux_conv_done;
  logic        aux_cal_done;
  logic        aux_clamped;
  logic        aux_cal_fault;
  logic [15:0] aux_value;
  logic        ref_bad;
  logic        pri_enable;
  logic        aux_enable;
  logic [2:0]  mode_select_field;
  logic [7:0]  primary_config_reg;
  logic [7:0]  auxiliary_config_reg;
  logic [7:0]  sinc_decimation_reg;
  int          errors;
  int          checks_done;

  dasf_status i_dut (
    .clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .bit_addr(bit_addr), .bit_wr(bit_wr),
    .bit_rd(bit_rd), .bit_wdata(bit_wdata), .bit_rdata(bit_rdata),
    .pri_conv_done(pri_conv_done), .pri_cal_done(pri_cal_done),
    .pri_clamped(pri_clamped), .pri_cal_fault(pri_cal_fault),
    .pri_value(pri_value), .aux_conv_done(aux_conv_done),
    .aux_cal_done(aux_cal_done), .aux_clamped(aux_clamped),
    .aux_cal_fault(aux_cal_fault), .aux_value(aux_value),
    .reference_input_pins_bad(ref_bad), .pri_enable(pri_enable),
    .aux_enable(aux_enable), .mode_select_field(mode_select_field),
    .primary_config_reg(primary_config_reg),
    .auxiliary_config_reg(auxiliary_config_reg),
    .sinc_decimation_reg(sinc_decimation_reg)
  );

  // ********************************************************
  // shared tasks
  // ********************************************************
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string what);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge clk);
    sfr_wr    = 1'b0;
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge clk);
    sfr_rd   = 1'b0;
    chk(sfr_rdata, exp, $sformatf("reg %h", a));
  endtask : rc

  task automatic bw(input logic [2:0] n, input logic v);
    @(negedge clk);
    bit_addr  = 8'hd8 + 8'(n);
    bit_wdata = v;
    bit_wr    = 1'b1;
    @(negedge clk);
    bit_wr    = 1'b0;
  endtask : bw

  task automatic br(input logic [2:0] n, input logic exp);
    @(negedge clk);
    bit_addr = 8'hd8 + 8'(n);
    bit_rd   = 1'b1;
    @(negedge clk);
    bit_rd   = 1'b0;
    chk(8'(bit_rdata), 8'(exp), $sformatf("bit %0d", n));
  endtask : br

  // k: 0 primary conv, 1 primary cal, 2 aux conv, 3 aux cal
  task automatic ev(input int k, input logic [15:0] v, input logic f);
    @(negedge clk);
    pri_value     = v;
    aux_value     = v;
    pri_clamped   = f;
    pri_cal_fault = f;
    aux_clamped   = f;
    aux_cal_fault = f;
    {pri_conv_done, pri_cal_done, aux_conv_done, aux_cal_done} =
      4'b1000 >> k;
    @(negedge clk);
    {pri_conv_done, pri_cal_done, aux_conv_done, aux_cal_done} = 4'h0;
  endtask : ev

  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic t_reset;
    rc(dasf_pkg::ADDR_STATUS, 8'h00);
    rc(dasf_pkg::ADDR_PRI_OFS_HI, 8'h80);
    rc(dasf_pkg::ADDR_AUX_GAIN_HI, 8'h55);
    rc(dasf_pkg::ADDR_SINC, 8'h45);
    rc(8'h80, 8'h00);
    wr(dasf_pkg::ADDR_AUX_CFG, 8'h3c);
    chk(auxiliary_config_reg, 8'h3c, "aux config");
    wr(dasf_pkg::ADDR_SINC, 8'h12);
    rc(dasf_pkg::ADDR_SINC, 8'h12);
    $display("reset test done");
  endtask : t_reset

  task automatic t_ready;
    wr(dasf_pkg::ADDR_MODE, 8'h23);
    ev(0, 16'h1234, 1'b0);
    rc(dasf_pkg::ADDR_STATUS, 8'h80);
    rc(dasf_pkg::ADDR_PRI_RES_HI, 8'h12);
    ev(0, 16'habcd, 1'b0);
    rc(dasf_pkg::ADDR_PRI_RES_LO, 8'h34);
    br(3'd7, 1'b1);
    br(3'd0, 1'b0);
    bw(3'd7, 1'b0);
    rc(dasf_pkg::ADDR_STATUS, 8'h00);
    ev(0, 16'h5678, 1'b0);
    rc(dasf_pkg::ADDR_PRI_RES_LO, 8'h78);
    $display("ready test done");
  endtask : t_ready

  task automatic t_aux;
    wr(dasf_pkg::ADDR_MODE, 8'h33);
    chk({3'b000, pri_enable, aux_enable, mode_select_field}, 8'h1b,
        "enables and mode");
    ev(2, 16'h00ff, 1'b1);
    rc(dasf_pkg::ADDR_STATUS, 8'h44);
    rc(dasf_pkg::ADDR_AUX_RES_LO, 8'hff);
    wr(dasf_pkg::ADDR_STATUS, 8'h00);
    rc(dasf_pkg::ADDR_STATUS, 8'h04);
    wr(dasf_pkg::ADDR_MODE, 8'h33);
    rc(dasf_pkg::ADDR_STATUS, 8'h00);
    wr(dasf_pkg::ADDR_MODE, 8'h17);
    ev(3, 16'h0a0b, 1'b0);
    rc(dasf_pkg::ADDR_AUX_GAIN_LO, 8'h0b);
    rc(dasf_pkg::ADDR_STATUS, 8'h60);
    wr(dasf_pkg::ADDR_STATUS, 8'h00);
    $display("auxiliary test done");
  endtask : t_aux

  task automatic t_cal;
    wr(dasf_pkg::ADDR_MODE, 8'h24);
    ev(1, 16'h0102, 1'b0);
    rc(dasf_pkg::ADDR_STATUS, 8'ha0);
    rc(dasf_pkg::ADDR_PRI_OFS_LO, 8'h02);
    bw(3'd7, 1'b0);
    wr(dasf_pkg::ADDR_STATUS, 8'h00);
    rc(dasf_pkg::ADDR_STATUS, 8'h20);
    wr(dasf_pkg::ADDR_MODE, 8'h25);
    rc(dasf_pkg::ADDR_STATUS, 8'h00);
    ev(1, 16'h0303, 1'b1);
    rc(dasf_pkg::ADDR_STATUS, 8'ha8);
    rc(dasf_pkg::ADDR_PRI_GAIN_LO, 8'h55);
    $display("calibration test done");
  endtask : t_cal

  task automatic t_single;
    wr(dasf_pkg::ADDR_MODE, 8'h22);
    ev(0, 16'h4321, 1'b0);
    rc(dasf_pkg::ADDR_MODE, 8'h20);
    wr(dasf_pkg::ADDR_MODE, 8'h23);
    ev(0, 16'hffff, 1'b1);
    rc(dasf_pkg::ADDR_STATUS, 8'h88);
    wr(dasf_pkg::ADDR_MODE, 8'h23);
    rc(dasf_pkg::ADDR_STATUS, 8'h00);
    @(negedge clk);
    bit_addr      = 8'hdf;
    bit_wdata     = 1'b0;
    bit_wr        = 1'b1;
    pri_conv_done = 1'b1;
    @(negedge clk);
    bit_wr        = 1'b0;
    pri_conv_done = 1'b0;
    rc(dasf_pkg::ADDR_STATUS, 8'h88);
    $display("single and race test done");
  endtask : t_single

  task automatic t_ref;
    wr(dasf_pkg::ADDR_MODE, 8'h23);
    wr(dasf_pkg::ADDR_PRI_CFG, 8'h40);
    chk(primary_config_reg, 8'h40, "primary config");
    wr(dasf_pkg::ADDR_MODE, 8'h00);
    ref_bad = 1'b1;
    repeat (8) @(negedge clk);
    rc(dasf_pkg::ADDR_STATUS, 8'h00);
    wr(dasf_pkg::ADDR_MODE, 8'h23);
    repeat (8) @(negedge clk);
    rc(dasf_pkg::ADDR_STATUS, 8'h10);
    ev(0, 16'h1234, 1'b0);
    rc(dasf_pkg::ADDR_PRI_RES_HI, 8'hff);
    ref_bad = 1'b0;
    wr(dasf_pkg::ADDR_MODE, 8'h23);
    repeat (8) @(negedge clk);
    rc(dasf_pkg::ADDR_STATUS, 8'h00);
    $display("reference test done");
  endtask : t_ref

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // whole run needs well under a thousand cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    errors++;
    $display("watchdog expired");
    summarize();
  end

  initial
  begin
    {reset_n, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata} = '0;
    {sfr_addr, sfr_wdata, bit_addr, ref_bad} = '0;
    {pri_conv_done, pri_cal_done, pri_clamped, pri_cal_fault} = '0;
    {aux_conv_done, aux_cal_done, aux_clamped, aux_cal_fault} = '0;
    {pri_value, aux_value} = '0;
    errors      = 0;
    checks_done = 0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_ready();
    t_aux();
    t_cal();
    t_single();
    t_ref();
    summarize();
  end

endmodule : tb_top

bind dasf_status dasf_assertions i_chk (
  .clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .bit_addr(bit_addr), .bit_wr(bit_wr),
  .bit_rd(bit_rd), .bit_wdata(bit_wdata), .bit_rdata(bit_rdata),
  .pri_conv_done(pri_conv_done), .pri_cal_done(pri_cal_done),
  .pri_value(pri_value), .pri_enable(pri_enable),
  .mode_select_field(mode_select_field),
  .primary_config_reg(primary_config_reg),
  .sinc_decimation_reg(sinc_decimation_reg)
);
